// *** tb/flame_relay_assertions.sv ***
`timescale 1ns/1ps
module flame_relay_assertions #(
    parameter int TickCycles = 50
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic bypassSel,
    input wire logic lensCheckTest,
    input wire logic [2:0] leadOpen,
    input wire logic [2:0] leadShort,
    input wire logic [2:0] leadGround,
    input wire logic [2:0] supplyFail,
    input wire logic [2:0] coilOpen,
    input wire logic [2:0] relayAbsent,
    input wire logic [3:0] boardMissing,
    input wire logic alarmRelay,
    input wire logic extinguishRelay,
    input wire logic faultRelay,
    input wire logic testLamp
);
    localparam int MinHold = 199 * TickCycles - 8;
    logic anyFault;
    int hiCnt;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    assign anyFault = |{leadOpen, leadShort, leadGround, supplyFail, coilOpen, relayAbsent, boardMissing};
    // cycles the alarm relay has been energized without a break
    always_ff @(posedge ref_clk) begin
        hiCnt <= alarmRelay ? hiCnt + 1 : 0;
    end
    ready_one_cycle_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    ready_no_wait_a: assert property (psel && !penable |=> pready) else $error("pready late");
    error_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    bypass_inhibit_a: assert property (bypassSel [*5] |-> !alarmRelay && !extinguishRelay)
        else $error("relay on in bypass");
    bypass_fault_a: assert property (bypassSel [*5] |-> !faultRelay)
        else $error("fault relay on in bypass");
    fault_drop_a: assert property (anyFault [*5] |-> !faultRelay)
        else $error("fault relay on with fault");
    fault_clean_rise_a: assert property ($rose(faultRelay) |-> !$past(anyFault, 3) && !$past(bypassSel, 3))
        else $error("fault relay rose while faulted");
    extinguish_hold_a: assert property ($rose(extinguishRelay) |-> hiCnt >= MinHold || $past(bypassSel, 8))
        else $error("extinguish relay early");
    lamp_follow_a: assert property (lensCheckTest [*5] |-> testLamp)
        else $error("test lamp off while pressed");
endmodule : flame_relay_assertions

// *** tb/test_flame_alarm_relay.sv ***
`timescale 1ns/1ps
module test_flame_alarm_relay;
    localparam int TickCycles = 5;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic bypassSel = 1'b0;
    logic lensCheckTest = 1'b0;
    logic remoteReset = 1'b0;
    logic pulseOn = 1'b0;
    logic [2:0] detSel = 3'h5;
    logic [21:0] faultPins = 22'h0;
    logic [7:0] detPulse;
    logic [31:0] prdata;
    logic [31:0] rdData;
    logic pready, pslverr, rdErr, alarmRelay, extinguishRelay, faultRelay, testLamp, irq;
    logic [4:0] outs;
    int n_errors = 0;
    int check_count = 0;
    time t0;

    assign outs = {irq, testLamp, faultRelay, extinguishRelay, alarmRelay};
    always #10 ref_clk = ~ref_clk;

    uv_detector_model i_uv_detector_model (.ref_clk, .enable(pulseOn), .sel(detSel), .detPulse);
    flame_alarm_relay #(.TickCycles(TickCycles)) i_flame_alarm_relay (.ref_clk, .rst_n, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .detPulse, .bypassSel, .lensCheckTest, .remoteReset,
        .leadOpen(faultPins[2:0]), .leadShort(faultPins[5:3]), .leadGround(faultPins[8:6]),
        .supplyFail(faultPins[11:9]), .coilOpen(faultPins[14:12]), .relayAbsent(faultPins[17:15]),
        .boardMissing(faultPins[21:18]), .alarmRelay, .extinguishRelay, .faultRelay, .testLamp, .irq);

    task automatic conclude();
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // request held until pready is seen high at a rising edge; data taken at that edge
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rdData, exp);
    endtask : rd

    task automatic waitOut(input int b, input logic v, input int lim);
        int n;
        n = 0;
        @(negedge ref_clk);
        while (outs[b] !== v && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        check(32'(outs[b]), 32'(v));
    endtask : waitOut

    task automatic stay(input int b, input logic v, input int k);
        repeat (k) @(negedge ref_clk);
        check(32'(outs[b]), 32'(v));
    endtask : stay

    task automatic span();
        time c;
        c = ($time - t0) / 20;
        check(32'(c > 200 * TickCycles - 20 && c < 200 * TickCycles + 20), 32'h1);
    endtask : span

    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        waitOut(2, 1'b1, 8);
        rd(flame_relay_pkg::ADDR_THRESH, 32'h14);
        rd(flame_relay_pkg::ADDR_DELAY, 32'h3e8);
        rd(flame_relay_pkg::ADDR_IRQ_MASK, 32'h0);
        rd(flame_relay_pkg::ADDR_CTRL, 32'h0);
        rd(flame_relay_pkg::ADDR_STATUS, 32'h4);
        rd(flame_relay_pkg::ADDR_RATE, 32'h0);
        rd(8'h1c, 32'h0);
        check(32'(rdErr), 32'h1);
        xfer(1'b1, flame_relay_pkg::ADDR_DELAY, 32'hffff);
        rd(flame_relay_pkg::ADDR_DELAY, 32'h2ee0);
        xfer(1'b1, flame_relay_pkg::ADDR_DELAY, 32'h1);
        rd(flame_relay_pkg::ADDR_DELAY, 32'hc8);
        xfer(1'b1, flame_relay_pkg::ADDR_THRESH, 32'h3);
        xfer(1'b1, flame_relay_pkg::ADDR_IRQ_MASK, 32'h7);
        @(posedge ref_clk);
        pulseOn <= 1'b1;
        repeat (16) @(posedge ref_clk);
        pulseOn <= 1'b0;
        stay(0, 1'b0, 12);
        @(posedge ref_clk);
        pulseOn <= 1'b1;
        waitOut(0, 1'b1, 16);
        t0 = $time;
        waitOut(1, 1'b1, 1100);
        span();
        check(32'(irq), 32'h1);
        rd(flame_relay_pkg::ADDR_IRQ_STAT, 32'h3);
        stay(4, 1'b0, 3);
        rd(flame_relay_pkg::ADDR_IRQ_STAT, 32'h0);
        @(posedge ref_clk);
        bypassSel <= 1'b1;
        waitOut(0, 1'b0, 8);
        waitOut(1, 1'b0, 8);
        waitOut(2, 1'b0, 8);
        @(posedge ref_clk);
        bypassSel <= 1'b0;
        waitOut(2, 1'b1, 8);
        @(posedge ref_clk);
        pulseOn <= 1'b0;
        waitOut(0, 1'b0, 10100);
        check(32'(extinguishRelay), 32'h0);
        rd(flame_relay_pkg::ADDR_RATE, 32'h0);
        detSel <= 3'h2;
        pulseOn <= 1'b1;
        waitOut(0, 1'b1, 40);
        t0 = $time;
        waitOut(1, 1'b1, 1100);
        span();
        @(posedge ref_clk);
        lensCheckTest <= 1'b1;
        waitOut(3, 1'b1, 8);
        @(posedge ref_clk);
        lensCheckTest <= 1'b0;
        waitOut(3, 1'b0, 8);
        xfer(1'b1, flame_relay_pkg::ADDR_CTRL, 32'h2);
        waitOut(3, 1'b1, 4);
        rd(flame_relay_pkg::ADDR_CTRL, 32'h2);
        xfer(1'b1, flame_relay_pkg::ADDR_CTRL, 32'h0);
        rd(flame_relay_pkg::ADDR_IRQ_STAT, 32'h7);
        xfer(1'b1, flame_relay_pkg::ADDR_IRQ_MASK, 32'h0);
        for (int i = 0; i < 22; i++) begin
            @(posedge ref_clk);
            faultPins <= 22'h1 << i;
            waitOut(2, 1'b0, 8);
            @(posedge ref_clk);
            faultPins <= 22'h0;
            stay(2, 1'b0, 8);
            if (i == 0) begin
                rd(flame_relay_pkg::ADDR_STATUS, 32'h2b);
                xfer(1'b1, flame_relay_pkg::ADDR_CTRL, 32'h4);
            end else begin
                @(posedge ref_clk);
                remoteReset <= 1'b1;
                repeat (4) @(posedge ref_clk);
                remoteReset <= 1'b0;
            end
            waitOut(2, 1'b1, 8);
        end
        check(32'(irq), 32'h0);
        rd(flame_relay_pkg::ADDR_IRQ_STAT, 32'h4);
        conclude();
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        n_errors++;
        conclude();
    end
endmodule : test_flame_alarm_relay

bind flame_alarm_relay flame_relay_assertions #(.TickCycles(TickCycles)) i_flame_relay_assertions (.ref_clk, .rst_n,
    .psel, .penable, .pready, .pslverr, .bypassSel, .lensCheckTest, .leadOpen, .leadShort, .leadGround, .supplyFail,
    .coilOpen, .relayAbsent, .boardMissing, .alarmRelay, .extinguishRelay, .faultRelay, .testLamp);

// *** tb/uv_detector_model.sv ***
`timescale 1ns/1ps
module uv_detector_model (
    input wire logic ref_clk,
    input wire logic enable,
    input wire logic [2:0] sel,
    output logic [7:0] detPulse
);
    logic [2:0] phase = 3'h0;
    // one pulse per 8 cycles, 4 high and 4 low; an idle detector is an open switch, line low
    always @(posedge ref_clk) begin
        phase <= enable ? phase + 3'h1 : 3'h0;
        detPulse <= (enable && phase[2]) ? 8'h01 << sel : 8'h00;
    end
endmodule : uv_detector_model

// *** verilog/flame_alarm_relay.sv ***
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
//
// Contract
// - alarm relay on at once above threshold
// - extinguish only after continuous above-threshold delay
// - extinguish delay adjustable 0.2 to 12 s
// - fault relay energized unless a fault present; code keeps a fault latched until remote reset or CTRL_FAULT_RESET
// - bypass counts as fault, drops fault relay
// - detector lead open or short flags fault
// - power supply failure flags fault
// - relay coil open or relay absent faults
// - any of four boards missing faults
// - wiring supervised continuously, not by scan
// - pulses integrated so comparison uses rate
// - sensitivity is a count; higher is less sensitive
// - bypass inhibits alarm and extinguish relays
// - lens check button lights detector test lamp
module flame_alarm_relay #(
    parameter int TickCycles = flame_relay_pkg::TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] detPulse,
    input wire logic bypassSel,
    input wire logic lensCheckTest,
    input wire logic remoteReset,
    input wire logic [2:0] leadOpen,
    input wire logic [2:0] leadShort,
    input wire logic [2:0] leadGround,
    input wire logic [2:0] supplyFail,
    input wire logic [2:0] coilOpen,
    input wire logic [2:0] relayAbsent,
    input wire logic [3:0] boardMissing,
    output logic alarmRelay,
    output logic extinguishRelay,
    output logic faultRelay,
    output logic testLamp,
    output logic irq
);
    localparam int NR = flame_relay_pkg::NUM_RAW;
    localparam int ND = flame_relay_pkg::NUM_DET;
    localparam int NF = flame_relay_pkg::NUM_FAULT;
    localparam logic [15:0] TICK_LAST = 16'(TickCycles - 1);

    typedef struct packed {
        logic [NR-1:0] sync1;
        logic [NR-1:0] sync2;
        logic [ND-1:0] detPrev;
        logic [15:0] tickCnt;
        logic msTick;
        logic [3:0] pulseCnt;
        logic [1:0] ctrl;
        logic [15:0] threshold;
        logic [15:0] delayMs;
        logic [15:0] dlyCnt;
        logic [2:0] irqStat;
        logic [2:0] irqMask;
        logic faultLatched;
        logic alarm;
        logic extinguish;
        logic faultOut;
        logic lamp;
        logic irqOut;
        logic ready;
        logic slvErr;
        logic [31:0] rdata;
    } relay_state_type;

    relay_state_type state_q;
    relay_state_type state_d;

    rate_if rif ();

    rate_integrator u_integ (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .rif(rif)
    );

    assign rif.pulses = state_q.pulseCnt;
    assign rif.msTick = state_q.msTick;
    assign rif.threshold = state_q.threshold;

    always_comb begin
        logic [NR-1:0] raw;
        logic [ND-1:0] rise;
        logic [NF-1:0] faults;
        logic bypass;
        logic above;
        logic faultNow;
        logic resetReq;
        logic setup;
        logic access;
        logic [2:0] events;
        logic [15:0] wval;

        state_d = state_q;
        raw = {boardMissing, relayAbsent, coilOpen, supplyFail, leadGround, leadShort, leadOpen,
               remoteReset, lensCheckTest, bypassSel, detPulse};
        rise = '0;
        events = 3'h0;
        resetReq = 1'b0;
        wval = pwdata[15:0];
        faults = '0;
        bypass = 1'b0;
        above = 1'b0;
        faultNow = 1'b0;
        setup = 1'b0;
        access = 1'b0;

        // two-stage synchronisers for every detector, switch and fault pin
        state_d.sync1 = raw;
        state_d.sync2 = state_q.sync1;
        state_d.detPrev = state_q.sync2[ND-1:0];

        // count detector pulse edges this cycle
        state_d.pulseCnt = 4'h0;
        for (int i = 0; i < ND; i++) begin
            rise[i] = state_q.sync2[i] & ~state_q.detPrev[i];
            state_d.pulseCnt = state_d.pulseCnt + 4'(rise[i]);
        end

        // millisecond timebase
        state_d.msTick = 1'b0;
        if (state_q.tickCnt == TICK_LAST) begin
            state_d.tickCnt = 16'h0000;
            state_d.msTick = 1'b1;
        end else begin
            state_d.tickCnt = state_q.tickCnt + 16'h0001;
        end

        faults = state_q.sync2[flame_relay_pkg::POS_FAULT +: NF];
        bypass = state_q.sync2[flame_relay_pkg::POS_BYPASS] | state_q.ctrl[flame_relay_pkg::CTRL_BYPASS];
        above = rif.above;

        // apb slave: zero wait states, answer in the first access cycle
        setup = psel & ~penable & ~state_q.ready;
        access = psel & penable & state_q.ready;
        state_d.ready = 1'b0;
        state_d.slvErr = 1'b0;
        if (setup) begin
            state_d.ready = 1'b1;
            state_d.rdata = 32'h0000_0000;
            unique case (paddr)
                flame_relay_pkg::ADDR_CTRL: state_d.rdata = {30'h0, state_q.ctrl};
                flame_relay_pkg::ADDR_THRESH: state_d.rdata = {16'h0000, state_q.threshold};
                flame_relay_pkg::ADDR_DELAY: state_d.rdata = {16'h0000, state_q.delayMs};
                flame_relay_pkg::ADDR_STATUS: state_d.rdata = {2'h0, faults, 2'h0, state_q.faultLatched,
                                                               bypass, above, state_q.faultOut,
                                                               state_q.extinguish, state_q.alarm};
                flame_relay_pkg::ADDR_IRQ_STAT: state_d.rdata = {29'h0, state_q.irqStat};
                flame_relay_pkg::ADDR_IRQ_MASK: state_d.rdata = {29'h0, state_q.irqMask};
                flame_relay_pkg::ADDR_RATE: state_d.rdata = {16'h0000, rif.lastCount};
                default: state_d.slvErr = 1'b1;
            endcase
        end
        if (access && pwrite) begin
            unique case (paddr)
                flame_relay_pkg::ADDR_CTRL: begin
                    state_d.ctrl = pwdata[1:0];
                    resetReq = pwdata[flame_relay_pkg::CTRL_FAULT_RESET];
                end
                flame_relay_pkg::ADDR_THRESH: state_d.threshold = wval;
                flame_relay_pkg::ADDR_DELAY: begin
                    // clamp to the adjustable range
                    if (wval < flame_relay_pkg::DELAY_MIN_MS) begin
                        state_d.delayMs = flame_relay_pkg::DELAY_MIN_MS;
                    end else if (wval > flame_relay_pkg::DELAY_MAX_MS) begin
                        state_d.delayMs = flame_relay_pkg::DELAY_MAX_MS;
                    end else begin
                        state_d.delayMs = wval;
                    end
                end
                flame_relay_pkg::ADDR_IRQ_MASK: state_d.irqMask = pwdata[2:0];
                default: ;
            endcase
        end
        if (access && !pwrite && paddr == flame_relay_pkg::ADDR_IRQ_STAT) begin
            // clear only what the read reported, so a late event survives
            state_d.irqStat = state_q.irqStat & ~state_q.rdata[2:0];
        end

        // instantaneous alarm, locked out in bypass
        state_d.alarm = above & ~bypass;

        // delay restarts from zero whenever the rate falls back
        if (!above || bypass) begin
            state_d.dlyCnt = 16'h0000;
        end else if (state_q.msTick && state_q.dlyCnt < state_q.delayMs) begin
            state_d.dlyCnt = state_q.dlyCnt + 16'h0001;
        end
        state_d.extinguish = above & ~bypass & (state_d.dlyCnt >= state_q.delayMs);

        // fault supervision is evaluated every cycle
        faultNow = |faults;
        resetReq = resetReq | state_q.sync2[flame_relay_pkg::POS_REMOTE];
        state_d.faultLatched = faultNow | (state_q.faultLatched & ~resetReq);
        state_d.faultOut = ~(state_d.faultLatched | bypass);

        // lens check drives the detector test lamp
        state_d.lamp = state_q.sync2[flame_relay_pkg::POS_LENS] | state_q.ctrl[flame_relay_pkg::CTRL_LENS];

        // sticky interrupt events, set wins over clear
        events[flame_relay_pkg::IRQ_ALARM] = state_d.alarm & ~state_q.alarm;
        events[flame_relay_pkg::IRQ_EXTINGUISH] = state_d.extinguish & ~state_q.extinguish;
        events[flame_relay_pkg::IRQ_FAULT] = ~state_d.faultOut & state_q.faultOut;
        state_d.irqStat = state_d.irqStat | events;
        state_d.irqOut = |(state_d.irqStat & state_d.irqMask);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= '0;
            state_q.threshold <= flame_relay_pkg::THRESH_RST;
            state_q.delayMs <= flame_relay_pkg::DELAY_RST;
            state_q.irqMask <= flame_relay_pkg::MASK_RST;
            state_q.ctrl <= flame_relay_pkg::CTRL_RST;
        end else begin
            state_q <= state_d;
        end
    end

    assign prdata = state_q.rdata;
    assign pready = state_q.ready;
    assign pslverr = state_q.slvErr;
    assign alarmRelay = state_q.alarm;
    assign extinguishRelay = state_q.extinguish;
    assign faultRelay = state_q.faultOut;
    assign testLamp = state_q.lamp;
    assign irq = state_q.irqOut;
endmodule : flame_alarm_relay

// *** verilog/flame_relay_pkg.sv ***
package flame_relay_pkg;
    // timebase
    localparam int CLK_MHZ = 50;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int WINDOW_MS = 1000;
    localparam logic [15:0] WINDOW_LAST = 16'(WINDOW_MS - 1);

    // extinguish delay limits in milliseconds, and register reset values
    localparam logic [15:0] DELAY_MIN_MS = 16'h00c8;
    localparam logic [15:0] DELAY_MAX_MS = 16'h2ee0;
    localparam logic [15:0] DELAY_RST = 16'h03e8;
    localparam logic [15:0] THRESH_RST = 16'h0014;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam logic [1:0] CTRL_RST = 2'h0;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_THRESH = 8'h04;
    localparam logic [7:0] ADDR_DELAY = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_RATE = 8'h18;

    // control bits
    localparam int CTRL_BYPASS = 0;
    localparam int CTRL_LENS = 1;
    localparam int CTRL_FAULT_RESET = 2;

    // interrupt bits
    localparam int IRQ_ALARM = 0;
    localparam int IRQ_EXTINGUISH = 1;
    localparam int IRQ_FAULT = 2;

    // positions in the synchronised pin vector
    localparam int NUM_DET = 8;
    localparam int NUM_FAULT = 22;
    localparam int NUM_RAW = NUM_DET + 3 + NUM_FAULT;
    localparam int POS_BYPASS = 8;
    localparam int POS_LENS = 9;
    localparam int POS_REMOTE = 10;
    localparam int POS_FAULT = 11;
endpackage : flame_relay_pkg

// *** verilog/rate_if.sv ***
`timescale 1ns/1ps
interface rate_if;
    logic [3:0] pulses;
    logic msTick;
    logic [15:0] threshold;
    logic above;
    logic [15:0] lastCount;

    modport feeder (output pulses, output msTick, output threshold, input above, input lastCount);
    modport integ (input pulses, input msTick, input threshold, output above, output lastCount);
endinterface : rate_if

// *** verilog/rate_integrator.sv ***
`timescale 1ns/1ps
module rate_integrator (
    input wire logic ref_clk,
    input wire logic rst_n,
    rate_if.integ rif
);
    typedef struct packed {
        logic [15:0] winMs;
        logic [15:0] acc;
        logic [15:0] last;
        logic above;
    } integ_state_type;

    integ_state_type state_q;
    integ_state_type state_d;

    always_comb begin
        logic [16:0] sum;
        logic [15:0] accSat;
        state_d = state_q;
        // accumulate pulses, saturating so a storm cannot wrap to zero
        sum = {1'b0, state_q.acc} + 17'(rif.pulses);
        accSat = sum[16] ? 16'hffff : sum[15:0];
        state_d.acc = accSat;
        // the running count reaching the threshold trips at once
        if (accSat >= rif.threshold) begin
            state_d.above = 1'b1;
        end
        if (rif.msTick) begin
            if (state_q.winMs == flame_relay_pkg::WINDOW_LAST) begin
                // window closes: the rate over the whole window decides
                state_d.winMs = 16'h0000;
                state_d.last = accSat;
                state_d.above = (accSat >= rif.threshold);
                state_d.acc = 16'h0000;
            end else begin
                state_d.winMs = state_q.winMs + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign rif.above = state_q.above;
    assign rif.lastCount = state_q.last;
endmodule : rate_integrator
